//--- hw/ofc_pkg.sv
// Constants shared by the output frame and calibration register bank
package ofc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_ACCESS     = 8'h01;
  localparam logic [7:0] IDX_FRAME      = 8'h10;
  localparam logic [7:0] IDX_PARITY     = 8'h11;
  localparam logic [7:0] IDX_OFFSET_CAL = 8'h18;
  localparam logic [7:0] IDX_MRG_VAL    = 8'h19;
  localparam logic [7:0] IDX_MRG_EN     = 8'h1A;
  localparam logic [7:0] IDX_HALF_MRG   = 8'h1B;

  // ==========================================================
  // Field positions
  localparam int FMT_LSB      = 4;
  localparam int DEBUG_BIT    = 0;
  localparam int PARITY_BIT   = 2;
  localparam int REF_SEL_LSB  = 0;
  localparam int MRG_VAL_LSB  = 0;
  localparam int MRG_EN_BIT   = 0;
  localparam int HALF_OFS_LSB = 4;
  localparam int HALF_EN_BIT  = 0;
  localparam int UNLOCK_BIT   = 0;

  // ==========================================================
  // Field widths
  localparam int FMT_W     = 2;
  localparam int REF_SEL_W = 3;
  localparam int MRG_W     = 5;
  localparam int HALF_W    = 3;
  localparam int RES_W     = 16;
  localparam int ID_W      = 4;
  localparam int STS_W     = 4;
  localparam int CFG_W     = 2;
  localparam int LEN_W     = 6;
  localparam int RANGE_N   = 6;

  // ==========================================================
  // Frame format codes and the debug pattern
  localparam logic [1:0] FMT_RESULT = 2'h0;
  localparam logic [1:0] FMT_ID     = 2'h1;
  localparam logic [1:0] FMT_FULL   = 2'h2;
  localparam logic [7:0] DEBUG_PATTERN = 8'hA6;
  localparam logic [5:0] DEBUG_LEN     = 6'h08;

  // ==========================================================
  // Reference range codes: 5.0, 4.5, 4.096, 3.3, 3.0, 2.5 V
  localparam logic [2:0] RANGE_5V0 = 3'h0;
  localparam logic [2:0] RANGE_4V5 = 3'h1;
  localparam logic [2:0] RANGE_4V1 = 3'h2;
  localparam logic [2:0] RANGE_3V3 = 3'h3;
  localparam logic [2:0] RANGE_3V0 = 3'h4;
  localparam logic [2:0] RANGE_2V5 = 3'h5;

  // Default unlock key; value is arbitrary
  localparam logic [7:0] UNLOCK_KEY = 8'h5A;

endpackage

//--- hw/ofc_regs.sv
// Output frame and calibration register bank with AHB-Lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module ofc_regs #(
  parameter logic [7:0] UNLOCK_VALUE = ofc_pkg::UNLOCK_KEY
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic [31:0]                        hrdata,
  output logic                               hresp,
  // Conversion sample in
  input  wire logic                          sample_valid,
  input  wire logic [ofc_pkg::RES_W-1:0]     sample_result,
  input  wire logic [ofc_pkg::ID_W-1:0]      sample_chan_id,
  input  wire logic [ofc_pkg::STS_W-1:0]     sample_status,
  input  wire logic [ofc_pkg::CFG_W-1:0]     sample_chan_cfg,
  // Serial frame out, right aligned, MSB sent first
  output logic                               frame_valid,
  output logic [31:0]                        frame_data,
  output logic [ofc_pkg::LEN_W-1:0]          frame_len,
  // Calibration controls to analog
  output logic [ofc_pkg::RANGE_N-1:0]        cal_range,
  output logic [ofc_pkg::MRG_W-1:0]          ref_margin_code,
  output logic                               ref_margin_active,
  output logic [ofc_pkg::HALF_W-1:0]         half_margin_code,
  output logic                               half_margin_active
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                          hready;
    logic [31:0]                   hrdata;
    logic                          wr_pend;
    logic [7:0]                    wr_idx;
    logic                          unlock;
    logic [ofc_pkg::FMT_W-1:0]     fmt;
    logic                          debug;
    logic                          parity_en;
    logic [ofc_pkg::REF_SEL_W-1:0] ref_sel;
    logic [ofc_pkg::MRG_W-1:0]     mrg_val;
    logic                          mrg_en;
    logic [ofc_pkg::HALF_W-1:0]    half_ofs;
    logic                          half_en;
    logic                          f_valid;
    logic [31:0]                   f_data;
    logic [ofc_pkg::LEN_W-1:0]     f_len;
    logic [ofc_pkg::RANGE_N-1:0]   range;
    logic [ofc_pkg::MRG_W-1:0]     mrg_out;
    logic                          mrg_act;
    logic [ofc_pkg::HALF_W-1:0]    half_out;
    logic                          half_act;
  } ofc_state_t;

  localparam ofc_state_t RESET_STATE = '{hready: 1'b1, default: '0};

  ofc_state_t q;
  ofc_state_t d;

  // Local copy of the frame length width, used in size casts
  localparam int LEN_W = ofc_pkg::LEN_W;

  // ==========================================================
  // Read mux; only documented fields are placed, the rest stay zero
  function automatic logic [31:0] read_reg(input ofc_state_t s, input logic [7:0] idx);
    logic [31:0] r;
    r = '0;
    unique case (idx)
      ofc_pkg::IDX_ACCESS:
      begin
        r[ofc_pkg::UNLOCK_BIT] = s.unlock;
      end
      ofc_pkg::IDX_FRAME:
      begin
        r[ofc_pkg::FMT_LSB +: ofc_pkg::FMT_W] = s.fmt;
        r[ofc_pkg::DEBUG_BIT] = s.debug;
      end
      ofc_pkg::IDX_PARITY:
      begin
        r[ofc_pkg::PARITY_BIT] = s.parity_en;
      end
      ofc_pkg::IDX_OFFSET_CAL:
      begin
        r[ofc_pkg::REF_SEL_LSB +: ofc_pkg::REF_SEL_W] = s.ref_sel;
      end
      ofc_pkg::IDX_MRG_VAL:
      begin
        r[ofc_pkg::MRG_VAL_LSB +: ofc_pkg::MRG_W] = s.mrg_val;
      end
      ofc_pkg::IDX_MRG_EN:
      begin
        r[ofc_pkg::MRG_EN_BIT] = s.mrg_en;
      end
      ofc_pkg::IDX_HALF_MRG:
      begin
        r[ofc_pkg::HALF_OFS_LSB +: ofc_pkg::HALF_W] = s.half_ofs;
        r[ofc_pkg::HALF_EN_BIT] = s.half_en;
      end
      default:
      begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // Index from a byte address, invalid (8'hFF) when above 10 address bits or not word aligned
  function automatic logic [7:0] addr_index(input logic [31:0] a);
    return (a[31:10] == '0 && a[1:0] == 2'h0) ? a[9:2] : 8'hFF;
  endfunction

  // ==========================================================
  // Next state
  logic [31:0]             fd;
  logic [ofc_pkg::LEN_W-1:0] fl;

  always_comb
  begin
    d = q;
    fd = '0;
    fl = '0;
    d.hready = 1'b1;
    d.f_valid = 1'b0;

    // Data phase of a write: commit into the addressed register
    if (q.wr_pend)
    begin
      unique case (q.wr_idx)
        ofc_pkg::IDX_ACCESS:
        begin
          d.unlock = (hwdata[7:0] == UNLOCK_VALUE);
        end
        ofc_pkg::IDX_FRAME:
        begin
          // Frame layout is locked like parity, keeping a frame change atomic
          if (q.unlock)
          begin
            d.fmt = hwdata[ofc_pkg::FMT_LSB +: ofc_pkg::FMT_W];
            d.debug = hwdata[ofc_pkg::DEBUG_BIT];
          end
        end
        ofc_pkg::IDX_PARITY:
        begin
          if (q.unlock)
          begin
            d.parity_en = hwdata[ofc_pkg::PARITY_BIT];
          end
        end
        ofc_pkg::IDX_OFFSET_CAL:
        begin
          d.ref_sel = hwdata[ofc_pkg::REF_SEL_LSB +: ofc_pkg::REF_SEL_W];
        end
        ofc_pkg::IDX_MRG_VAL:
        begin
          d.mrg_val = hwdata[ofc_pkg::MRG_VAL_LSB +: ofc_pkg::MRG_W];
        end
        ofc_pkg::IDX_MRG_EN:
        begin
          d.mrg_en = hwdata[ofc_pkg::MRG_EN_BIT];
        end
        ofc_pkg::IDX_HALF_MRG:
        begin
          d.half_ofs = hwdata[ofc_pkg::HALF_OFS_LSB +: ofc_pkg::HALF_W];
          d.half_en = hwdata[ofc_pkg::HALF_EN_BIT];
        end
        default:
        begin
          d.wr_pend = 1'b0;
        end
      endcase
    end

    // Address phase; reads see a write that commits this same cycle
    d.wr_pend = 1'b0;
    d.hrdata = '0;
    if (hsel && htrans[1] && hready)
    begin
      d.wr_pend = hwrite;
      d.wr_idx = addr_index(haddr);
      if (!hwrite)
      begin
        d.hrdata = read_reg(d, addr_index(haddr));
      end
    end

    // Frame assembly from the settings in force at the sample
    if (sample_valid)
    begin
      d.f_valid = 1'b1;
      if (q.debug)
      begin
        fd = 32'(ofc_pkg::DEBUG_PATTERN);
        fl = ofc_pkg::DEBUG_LEN;
      end
      else
      begin
        fd = 32'(sample_result);
        fl = LEN_W'(ofc_pkg::RES_W);
        // Reserved format code falls back to result only
        if (q.fmt == ofc_pkg::FMT_ID || q.fmt == ofc_pkg::FMT_FULL)
        begin
          fd = (fd << ofc_pkg::ID_W) | 32'(sample_chan_id);
          fl = fl + LEN_W'(ofc_pkg::ID_W);
        end
        if (q.fmt == ofc_pkg::FMT_FULL)
        begin
          fd = (fd << ofc_pkg::STS_W) | 32'(sample_status);
          fd = (fd << ofc_pkg::CFG_W) | 32'(sample_chan_cfg);
          fl = fl + LEN_W'(ofc_pkg::STS_W + ofc_pkg::CFG_W);
        end
        // Even parity over the whole frame; top bit is free at the widest format
        if (q.parity_en)
        begin
          fd = {fd[30:0], ^fd};
          fl = fl + LEN_W'(1);
        end
      end
      d.f_data = fd;
      d.f_len = fl;
    end

    // Calibration controls; 110b and 111b alias to the 5.0 V setting
    d.range = '0;
    if (q.ref_sel > ofc_pkg::RANGE_2V5)
    begin
      d.range[ofc_pkg::RANGE_5V0] = 1'b1;
    end
    else
    begin
      d.range[q.ref_sel] = 1'b1;
    end
    d.mrg_act = q.mrg_en;
    d.mrg_out = q.mrg_en ? q.mrg_val : '0;
    d.half_act = q.half_en;
    d.half_out = q.half_en ? q.half_ofs : '0;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= RESET_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = q.hready;
  assign hrdata = q.hrdata;
  assign hresp = 1'b0;
  assign frame_valid = q.f_valid;
  assign frame_data = q.f_data;
  assign frame_len = q.f_len;
  assign cal_range = q.range;
  assign ref_margin_code = q.mrg_out;
  assign ref_margin_active = q.mrg_act;
  assign half_margin_code = q.half_out;
  assign half_margin_active = q.half_act;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_parity_write_lock: assert property (
    (q.wr_pend && q.wr_idx == ofc_pkg::IDX_PARITY && !q.unlock) |=> $stable(q.parity_en))
    else $error("parity control changed while locked");

  a_debug_frame_pattern: assert property (
    (sample_valid && q.debug) |=> (frame_valid && frame_data == 32'h0000_00A6 && frame_len == 6'h08))
    else $error("debug frame not the fixed pattern");

  a_normal_result_only: assert property (
    (sample_valid && !q.debug && q.fmt == 2'h0 && !q.parity_en)
      |=> (frame_data == {16'h0000, $past(sample_result)} && frame_len == 6'h10))
    else $error("plain result frame wrong");

  a_full_format_len: assert property (
    (sample_valid && !q.debug && q.fmt == 2'h2 && !q.parity_en) |=> (frame_len == 6'h1A))
    else $error("full format length wrong");

  a_parity_adds_bit: assert property (
    (sample_valid && !q.debug && q.fmt == 2'h1 && q.parity_en)
      |=> (frame_len == 6'h15 && ^frame_data == 1'b0))
    else $error("parity frame wrong");

  a_range_alias_5v: assert property (
    (q.ref_sel[2:1] == 2'h3) |=> (cal_range == 6'h01))
    else $error("reserved range codes not mapped to 5.0 V");

  a_margin_gated: assert property (
    !ref_margin_active |-> (ref_margin_code == 5'h00))
    else $error("margin code passed while disabled");

  a_reserved_read_zero: assert property (
    hrdata[31:8] == 24'h000000
      && (q.wr_idx != ofc_pkg::IDX_PARITY || hrdata[1:0] == 2'h0)
      && (q.wr_idx != ofc_pkg::IDX_FRAME || (hrdata[7:6] == 2'h0 && hrdata[3:1] == 3'h0)))
    else $error("reserved bits read nonzero");

  a_frame_write_lock: assert property (
    (q.wr_pend && q.wr_idx == ofc_pkg::IDX_FRAME && !q.unlock) |=> ($stable(q.fmt) && $stable(q.debug)))
    else $error("frame control changed while locked");

  a_parity_write_open: assert property (
    (q.wr_pend && q.wr_idx == ofc_pkg::IDX_PARITY && q.unlock)
      |=> (q.parity_en == $past(hwdata[ofc_pkg::PARITY_BIT])))
    else $error("unlocked parity write not taken");

  a_frame_follows_sample: assert property (
    frame_valid == $past(sample_valid))
    else $error("frame valid not one cycle after sample");

  a_margin_follows_en: assert property (
    ref_margin_active == $past(q.mrg_en))
    else $error("margin active does not follow enable");

  a_range_one_hot: assert property (
    !$past(rst) |-> $onehot(cal_range))
    else $error("range select not one-hot");

  a_reset_clears: assert property (
    $past(rst) |-> (q.parity_en == 1'b0 && q.fmt == 2'h0 && !q.debug && !q.unlock && q.ref_sel == 3'h0))
    else $error("fields not cleared by reset");

  a_ready_always: assert property (
    hreadyout && !hresp)
    else $error("slave inserted wait or error");

endmodule

//--- bench/ofc_host_model.sv
// Host controller model: AHB-Lite master for single word transfers
`timescale 1ns/1ps
module ofc_host_model (
  // Clock
  input  wire logic        clk,
  // AHB-Lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ==========================================================
  // One transfer; no unlock is done here, so a write to a locked register is dropped unless the caller unlocked first
  // Offset calibration is written only because an external reference is assumed
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    // Stale write data is inverted so a late sample cannot pass by luck
    hwdata <= ~wd;
  endtask
endmodule

//--- bench/test_adc_output_frame_and_cal_regs.sv
// Self-checking testbench of the output frame and calibration register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_adc_output_frame_and_cal_regs;
  typedef struct packed { logic [7:0] idx; logic [7:0] wd; logic [7:0] rexp; } ofc_row_t;
  localparam logic [15:0] RES = 16'h1234;
  localparam logic [3:0]  CID = 4'h5;
  localparam logic [3:0]  STS = 4'h9;
  localparam logic [1:0]  CFG = 2'h3;
  logic clk = 1'b0, rst = 1'b1, hsel, hwrite, hreadyout, hresp, sample_valid = 1'b0, frame_valid;
  logic [31:0] haddr, hwdata, hrdata, frame_data, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize, half_margin_code;
  logic [5:0]  frame_len, cal_range;
  logic [4:0]  ref_margin_code;
  logic        ref_margin_active, half_margin_active;
  int n_fail = 0, n_checks = 0, cyc = 0;
  ofc_row_t rows [8] = '{
    '{ofc_pkg::IDX_ACCESS, 8'h5A, 8'h01}, '{ofc_pkg::IDX_FRAME, 8'hFF, 8'h31},
    '{ofc_pkg::IDX_PARITY, 8'hFF, 8'h04}, '{ofc_pkg::IDX_OFFSET_CAL, 8'hFF, 8'h07},
    '{ofc_pkg::IDX_MRG_VAL, 8'hFF, 8'h1F}, '{ofc_pkg::IDX_MRG_EN, 8'hFF, 8'h01},
    '{ofc_pkg::IDX_HALF_MRG, 8'hFF, 8'h71}, '{8'h3F, 8'hFF, 8'h00}};

  always #10 clk = ~clk;

  ofc_host_model u_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  ofc_regs DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sample_valid(sample_valid), .sample_result(RES), .sample_chan_id(CID),
    .sample_status(STS), .sample_chan_cfg(CFG), .frame_valid(frame_valid), .frame_data(frame_data),
    .frame_len(frame_len), .cal_range(cal_range), .ref_margin_code(ref_margin_code),
    .ref_margin_active(ref_margin_active), .half_margin_code(half_margin_code),
    .half_margin_active(half_margin_active));

  // ==========================================================
  // Helpers
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    u_host.xfer(idx, 1'b1, {24'h0, v}, rdv);
  endtask

  task automatic rd(input logic [7:0] idx);
    u_host.xfer(idx, 1'b0, 32'h0, rdv);
  endtask

  // Frame expected from the format and parity settings
  task automatic frame_chk(input logic [1:0] f, input logic p, input logic dbg);
    logic [31:0] d;
    logic [5:0]  n;
    d = (f == 2'h1) ? {12'h0, RES, CID} : (f == 2'h2) ? {6'h0, RES, CID, STS, CFG} : {16'h0, RES};
    n = (f == 2'h1) ? 6'h14 : (f == 2'h2) ? 6'h1A : 6'h10;
    if (p)
    begin
      d = {d[30:0], ^d};
      n = n + 6'h01;
    end
    if (dbg)
    begin
      d = 32'hA6;
      n = 6'h08;
    end
    @(posedge clk);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
    `CHK("frame_valid", 1'b1, frame_valid)
    `CHK("frame_data", d, frame_data)
    `CHK("frame_len", n, frame_len)
    @(posedge clk);
    #1;
    `CHK("frame_valid_end", 1'b0, frame_valid)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reserved bits of every row read back as zero
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx);
      `CHK("readback", {24'h0, rows[i].rexp}, rdv)
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(ofc_pkg::IDX_FRAME, {2'h0, 2'(k >> 1), 4'h0});
      wr(ofc_pkg::IDX_PARITY, {5'h0, 1'(k), 2'h0});
      frame_chk(2'(k >> 1), 1'(k), 1'b0);
    end
    wr(ofc_pkg::IDX_FRAME, 8'h01);
    frame_chk(2'h0, 1'b0, 1'b1);
    // Relock, then a write to frame control must be dropped
    wr(ofc_pkg::IDX_ACCESS, 8'h00);
    wr(ofc_pkg::IDX_FRAME, 8'h20);
    rd(ofc_pkg::IDX_FRAME);
    `CHK("locked_frame", 32'h01, rdv)
    wr(ofc_pkg::IDX_PARITY, 8'h00);
    rd(ofc_pkg::IDX_PARITY);
    `CHK("locked_parity", 32'h04, rdv)
    for (int r = 0; r < 8; r++)
    begin
      wr(ofc_pkg::IDX_OFFSET_CAL, 8'(r));
      repeat (2) @(posedge clk);
      `CHK("cal_range", (r > 5) ? 6'h01 : 6'(1 << r), cal_range)
    end
    wr(ofc_pkg::IDX_MRG_VAL, 8'h15);
    wr(ofc_pkg::IDX_MRG_EN, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("margin_off", 5'h00, ref_margin_code)
    `CHK("margin_act_off", 1'b0, ref_margin_active)
    wr(ofc_pkg::IDX_MRG_EN, 8'h01);
    wr(ofc_pkg::IDX_HALF_MRG, 8'h51);
    repeat (2) @(posedge clk);
    `CHK("margin_on", 5'h15, ref_margin_code)
    `CHK("margin_act", 1'b1, ref_margin_active)
    `CHK("half_code", 3'h5, half_margin_code)
    `CHK("half_act", 1'b1, half_margin_active)
    rd(ofc_pkg::IDX_MRG_VAL);
    `CHK("margin_val", 32'h15, rdv)
    // Second reset in mid-run: every register back to zero, range back to 5.0 V
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Parity control is locked again after reset
    wr(ofc_pkg::IDX_PARITY, 8'h04);
    rd(ofc_pkg::IDX_PARITY);
    `CHK("reset_locked", 32'h0, rdv)
    foreach (rows[i])
    begin
      rd(rows[i].idx);
      `CHK("reset_value", 32'h0, rdv)
    end
    `CHK("cal_reset", 6'h01, cal_range)
    `CHK("hresp", 1'b0, hresp)
    tally_and_finish();
  end
endmodule
